// >>> core/pocs_params.svh
// Offsets, field positions, reset values and timing counts for the pixel output block
// Assumes inclusion by the package and the design files
//
// Function
// (R1) Sample the strap pin after power-up; it becomes the serial address LSB.
// (R2) After the strap sample the pin drives vertical sync, unchanged by the strap.
// (R3) Red, green and blue leave as 10-bit words, bit 9 most significant.
// (R4) Sample instant to output takes a fixed number of clock cycles; here fixed only while sink_ready stays high, sink stalls add cycles.
// (R5) Phase register moves sampling, data, data clock and hsync together.
// (R6) Output clock control bits 7 to 6 choose one of four data clocks.
// (R7) Pixel, 90-degree and double-rate clocks stay synchronous with sampling.
// (R8) Fourth choice is a half-rate pixel clock made inside the block.
// (R9) Downstream logic captures data and hsync with the data clock; the bench sink captures on pclk while pixel_valid is high.
// (R10) Hsync output is rebuilt, aligned with data, polarity and width programmable.
// (R11) Select codes 00, 01, 10, 11 give pixel, 90-degree, double, half.
`ifndef POCS_PARAMS_SVH
`define POCS_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define POCS_OFS_PHASE      12'h004
`define POCS_OFS_OCLK       12'h020
`define POCS_OFS_STATUS     12'h024
`define POCS_OFS_HSCTL      12'h028

// ----------------------------------------------------------------
// Reset values and fields
// ----------------------------------------------------------------
`define POCS_RST_PHASE      8'h00
`define POCS_RST_OCLK       8'h00
`define POCS_RST_HSCTL      10'h010
`define POCS_PHASE_MSB      7
`define POCS_PHASE_LSB      3
`define POCS_CKSEL_MSB      7
`define POCS_CKSEL_LSB      6
`define POCS_HS_WIDTH_MSB   7
`define POCS_HS_POL_BIT     8
`define POCS_VS_POL_BIT     9
`define POCS_ST_STRAP_BIT   0
`define POCS_ST_DONE_BIT    1
`define POCS_ST_OVF_BIT     2
`define POCS_ST_HALF_LSB    8

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define POCS_CLK_NS         20
`define POCS_STRAP_WAIT_NS  1000
`define POCS_STRAP_WAIT_CYC ((`POCS_STRAP_WAIT_NS + `POCS_CLK_NS - 1) / `POCS_CLK_NS)
`define POCS_OUT_LAT        2
`define POCS_TAPS           32

`endif

// >>> core/pocs_pkg.sv
// Types shared by the pixel output block
// Assumes the params header is on the include path
package pocs_pkg;
`include "pocs_params.svh"

  // ----------------------------------------------------------------
  // Strap capture states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    POCS_ST_WAIT   = 2'b00,
    POCS_ST_SAMPLE = 2'b01,
    POCS_ST_RUN    = 2'b10
  } pocs_strap_st_t;

  // ----------------------------------------------------------------
  // Data clock choices
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    POCS_CK_PIX  = 2'b00,
    POCS_CK_P90  = 2'b01,
    POCS_CK_X2   = 2'b10,
    POCS_CK_HALF = 2'b11
  } pocs_cksel_t;
endpackage

// >>> core/pocs_stream_if.sv
// Valid/ready stream between the sampler and the two-entry buffer
// Assumes one clock shared by both ends
`timescale 1ns/10ps
interface pocs_stream_if #(parameter int W = 31);
  logic         in_valid;
  logic         in_ready;
  logic [W-1:0] in_data;
  logic         out_valid;
  logic         out_ready;
  logic [W-1:0] out_data;

  modport buf_side (input in_valid, input in_data, input out_ready,
                    output in_ready, output out_valid, output out_data);
  modport user_side (output in_valid, output in_data, output out_ready,
                     input in_ready, input out_valid, input out_data);
endinterface

// >>> core/pocs_buf2.sv
// Two-entry buffer with valid and ready on both sides
// Assumes pclk domain on both sides
`timescale 1ns/10ps
module pocs_buf2 #(
  parameter int W = 31
) (
  input  wire logic           pclk,
  input  wire logic           presetn,
  pocs_stream_if.buf_side     s
);
  import pocs_pkg::*;

  typedef struct packed {
    logic [1:0]   cnt;
    logic [W-1:0] e0;
    logic [W-1:0] e1;
  } pocs_buf_st_t;

  pocs_buf_st_t s_q;
  pocs_buf_st_t s_d;
  logic         push;
  logic         pop;

  assign s.in_ready  = (s_q.cnt != 2'd2);
  assign s.out_valid = (s_q.cnt != 2'd0);
  assign s.out_data  = s_q.e0;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d  = s_q;
    push = s.in_valid & s.in_ready;
    pop  = s.out_valid & s.out_ready;
    case ({push, pop})
      2'b10:
      begin
        if (s_q.cnt == 2'd0)
          s_d.e0 = s.in_data;
        else
          s_d.e1 = s.in_data;
        s_d.cnt = s_q.cnt + 2'd1;
      end
      2'b01:
      begin
        s_d.e0  = s_q.e1;
        s_d.cnt = s_q.cnt - 2'd1;
      end
      2'b11:
      begin
        if (s_q.cnt == 2'd1)
          s_d.e0 = s.in_data;
        else
        begin
          s_d.e0 = s_q.e1;
          s_d.e1 = s.in_data;
        end
      end
      default: s_d = s_q;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_buf_first_word: assert property (@(posedge pclk) disable iff (!presetn) // R4
    (s.in_valid && s_q.cnt == 2'd0) |=> (s.out_valid && s.out_data == $past(s.in_data)))
    else $error("buffer lost first word");
  a_buf_stall_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (s.out_valid && !s.out_ready) |=> (s.out_valid && $stable(s.out_data)))
    else $error("buffer head changed while stalled");
endmodule

// >>> core/pocs_top.sv
// Pixel output stage: sampling phase, data clock select, hsync rebuild, strap capture
// Assumes APB master on pclk; video pins arrive asynchronously
`timescale 1ns/10ps
`include "pocs_params.svh"
module pocs_top #(
  parameter int CH_W = 10
) (
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic [11:0]     paddr,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [31:0]     pwdata,
  input  wire logic [3:0]      pstrb,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  input  wire logic            external_sample_clock_in,
  input  wire logic            hsync_in,
  input  wire logic            vsync_in,
  input  wire logic [CH_W-1:0] adc_red,
  input  wire logic [CH_W-1:0] adc_green,
  input  wire logic [CH_W-1:0] adc_blue,
  input  wire logic            vertical_sync_output_i,
  output logic                 vertical_sync_output_o,
  output logic                 vertical_sync_output_oe,
  output logic [CH_W-1:0]      red_out,
  output logic [CH_W-1:0]      green_out,
  output logic [CH_W-1:0]      blue_out,
  output logic                 horizontal_sync_output,
  output logic                 data_strobe_clock_out,
  output logic                 pixel_valid,
  input  wire logic            sink_ready,
  output logic                 address_strap_lsb
);
  import pocs_pkg::*;

  localparam int IN_W = 3 * CH_W + 4;
  localparam int PW   = 3 * CH_W + 1;
  localparam int TAPW = `POCS_TAPS + `POCS_OUT_LAT;
  localparam int I_LC = IN_W - 1;
  localparam int I_HS = IN_W - 2;
  localparam int I_VS = IN_W - 3;
  localparam int I_ST = IN_W - 4;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0][IN_W-1:0] syn;
    logic [IN_W-1:0]      filt;
    logic                 lclk_prev;
    pocs_strap_st_t       st;
    logic [7:0]           wait_cnt;
    logic                 strap;
    logic [7:0]           phase;
    logic [7:0]           oclk;
    logic [9:0]           hsctl;
    logic                 ovf;
    logic [7:0]           half_cnt;
    logic [7:0]           half;
    logic [TAPW-1:0]      rise_sr;
    logic [TAPW-1:0]      fall_sr;
    logic [6:0]           q_cnt;
    logic                 q_after_fall;
    logic                 hs_prev;
    logic [7:0]           hs_cnt;
    logic                 push_v;
    logic [PW-1:0]        push_d;
    logic [CH_W-1:0]      red;
    logic [CH_W-1:0]      green;
    logic [CH_W-1:0]      blue;
    logic                 hs_out;
    logic                 pix_v;
    logic                 dclk;
    logic                 vs_o;
    logic                 vs_oe;
    logic [31:0]          prdata;
    logic                 pready;
    logic                 pslverr;
  } pocs_top_st_t;

  pocs_top_st_t     s_q;
  pocs_top_st_t     s_d;
  logic [IN_W-1:0]  in_vec;
  logic [4:0]       ph;
  logic [5:0]       tap_o;
  pocs_cksel_t      sel;
  logic             lclk;
  logic             rise;
  logic             fall;
  logic             ev_s;
  logic             ev_ro;
  logic             ev_fo;
  logic             ev_q;
  logic             hs_start;
  logic             hs_act;
  logic             acc;
  logic             hit;
  logic             wr_en;
  logic             ph_wr;

  pocs_stream_if #(.W(PW)) bs ();

  pocs_buf2 #(.W(PW)) u_buf (
    .pclk    (pclk),
    .presetn (presetn),
    .s       (bs)
  );

  assign in_vec       = {external_sample_clock_in, hsync_in, vsync_in, vertical_sync_output_i,
                         adc_red, adc_green, adc_blue};
  assign bs.in_valid  = s_q.push_v;
  assign bs.in_data   = s_q.push_d;
  assign bs.out_ready = sink_ready;

  // ----------------------------------------------------------------
  // Event decode
  // ----------------------------------------------------------------
  assign ph    = s_q.phase[`POCS_PHASE_MSB:`POCS_PHASE_LSB];
  assign tap_o = {1'b0, ph} + 6'(`POCS_OUT_LAT);
  assign sel   = pocs_cksel_t'(s_q.oclk[`POCS_CKSEL_MSB:`POCS_CKSEL_LSB]);
  assign lclk  = s_q.filt[I_LC];
  assign rise  = lclk & ~s_q.lclk_prev;
  assign fall  = ~lclk & s_q.lclk_prev;
  assign ev_s  = s_q.rise_sr[ph];
  assign ev_ro = s_q.rise_sr[tap_o];
  assign ev_fo = s_q.fall_sr[tap_o];
  assign ev_q  = (s_q.q_cnt == 7'd1);
  assign acc   = psel & penable;
  assign hit   = (paddr == `POCS_OFS_PHASE) || (paddr == `POCS_OFS_OCLK) ||
                 (paddr == `POCS_OFS_STATUS) || (paddr == `POCS_OFS_HSCTL);
  assign wr_en = acc & s_q.pready & pwrite & hit;
  assign ph_wr = wr_en & (paddr == `POCS_OFS_PHASE);
  assign hs_start = ev_s & s_q.filt[I_HS] & ~s_q.hs_prev;
  assign hs_act   = hs_start | (s_q.hs_cnt != 8'd0);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    // Three-stage input sync, change taken once stages two and three agree
    s_d.syn  = {s_q.syn[1:0], in_vec};
    s_d.filt = (s_q.syn[1] & s_q.syn[2]) | (s_q.filt & (s_q.syn[1] ^ s_q.syn[2]));
    s_d.lclk_prev = lclk;
    // Link clock edges delayed by the phase setting
    s_d.rise_sr = {s_q.rise_sr[TAPW-2:0], rise}; // R5
    s_d.fall_sr = {s_q.fall_sr[TAPW-2:0], fall}; // R5
    // Half period measurement for quarter points
    if (rise)
      s_d.half_cnt = 8'd1;
    else if (s_q.half_cnt != 8'hFF)
      s_d.half_cnt = s_q.half_cnt + 8'd1;
    if (fall)
      s_d.half = s_q.half_cnt;
    if (ev_ro || ev_fo)
    begin
      s_d.q_cnt        = s_q.half[7:1];
      s_d.q_after_fall = ev_fo;
    end
    else if (s_q.q_cnt != 7'd0)
      s_d.q_cnt = s_q.q_cnt - 7'd1;

    // Data clock, all choices built from the same delayed edges
    case (sel) // R6 R11
      POCS_CK_PIX: // R7
      begin
        if (ev_ro)
          s_d.dclk = 1'b1;
        else if (ev_fo)
          s_d.dclk = 1'b0;
      end
      POCS_CK_P90: // R7
      begin
        if (ev_q)
          s_d.dclk = ~s_q.q_after_fall;
      end
      POCS_CK_X2: // R7
      begin
        if (ev_ro || ev_fo)
          s_d.dclk = 1'b1;
        else if (ev_q)
          s_d.dclk = 1'b0;
      end
      POCS_CK_HALF: // R8
      begin
        if (ev_ro)
          s_d.dclk = ~s_q.dclk;
      end
      default: s_d.dclk = 1'b0;
    endcase

    // Sampling and hsync rebuild
    s_d.push_v = ev_s; // R4 R5
    if (ev_s)
    begin
      s_d.hs_prev = s_q.filt[I_HS];
      if (hs_start)
        s_d.hs_cnt = (s_q.hsctl[`POCS_HS_WIDTH_MSB:0] == 8'd0) ? 8'd0 :
                     s_q.hsctl[`POCS_HS_WIDTH_MSB:0] - 8'd1; // R10
      else if (s_q.hs_cnt != 8'd0)
        s_d.hs_cnt = s_q.hs_cnt - 8'd1;
      s_d.push_d = {hs_act ^ s_q.hsctl[`POCS_HS_POL_BIT], s_q.filt[3*CH_W-1:0]}; // R10 R3
    end

    // Output stage, loaded when the receiver takes a word
    s_d.pix_v = bs.out_valid & sink_ready;
    if (bs.out_valid && sink_ready)
    begin
      s_d.hs_out = bs.out_data[PW-1]; // R10
      s_d.red    = bs.out_data[3*CH_W-1:2*CH_W]; // R3
      s_d.green  = bs.out_data[2*CH_W-1:CH_W]; // R3
      s_d.blue   = bs.out_data[CH_W-1:0]; // R3
    end

    // Strap capture then vertical sync drive
    case (s_q.st)
      POCS_ST_WAIT:
      begin
        s_d.vs_oe = 1'b0;
        if (s_q.wait_cnt == 8'd0)
          s_d.st = POCS_ST_SAMPLE;
        else
          s_d.wait_cnt = s_q.wait_cnt - 8'd1;
      end
      POCS_ST_SAMPLE:
      begin
        if (s_q.syn[1][I_ST] == s_q.syn[2][I_ST])
        begin
          s_d.strap = s_q.syn[2][I_ST]; // R1
          s_d.st    = POCS_ST_RUN;
          s_d.vs_oe = 1'b1; // R2
        end
      end
      POCS_ST_RUN:
      begin
        s_d.vs_oe = 1'b1; // R2
        s_d.vs_o  = s_q.filt[I_VS] ^ s_q.hsctl[`POCS_VS_POL_BIT]; // R2
      end
      default: s_d.st = POCS_ST_WAIT;
    endcase

    // APB slave, one wait state
    s_d.pready = acc & ~s_q.pready;
    if (acc && !s_q.pready)
    begin
      s_d.pslverr = ~hit;
      case (paddr)
        `POCS_OFS_PHASE:  s_d.prdata = {24'h000000, s_q.phase};
        `POCS_OFS_OCLK:   s_d.prdata = {24'h000000, s_q.oclk};
        `POCS_OFS_HSCTL:  s_d.prdata = {22'h000000, s_q.hsctl};
        `POCS_OFS_STATUS: s_d.prdata = {16'h0000, s_q.half, 5'h00, s_q.ovf,
                                        (s_q.st == POCS_ST_RUN), s_q.strap};
        default:          s_d.prdata = 32'h00000000;
      endcase
    end
    else if (!acc)
      s_d.pslverr = 1'b0;
    if (wr_en && pstrb[0])
    begin
      if (paddr == `POCS_OFS_PHASE)
        s_d.phase = pwdata[7:0]; // R5
      if (paddr == `POCS_OFS_OCLK)
        s_d.oclk = pwdata[7:0]; // R6
      if (paddr == `POCS_OFS_HSCTL)
        s_d.hsctl[7:0] = pwdata[7:0]; // R10
      if (paddr == `POCS_OFS_STATUS && pwdata[`POCS_ST_OVF_BIT])
        s_d.ovf = 1'b0;
    end
    if (wr_en && pstrb[1] && paddr == `POCS_OFS_HSCTL)
      s_d.hsctl[9:8] = pwdata[9:8]; // R10
    // Dropped sample flag, set wins over clear
    if (s_q.push_v && !bs.in_ready)
      s_d.ovf = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q          <= '0;
      s_q.st       <= POCS_ST_WAIT;
      s_q.wait_cnt <= 8'(`POCS_STRAP_WAIT_CYC - 1);
      s_q.phase    <= `POCS_RST_PHASE;
      s_q.oclk     <= `POCS_RST_OCLK;
      s_q.hsctl    <= `POCS_RST_HSCTL;
    end
    else
      s_q <= s_d;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata                  = s_q.prdata;
  assign pready                  = s_q.pready;
  assign pslverr                 = s_q.pslverr;
  assign vertical_sync_output_o  = s_q.vs_o;
  assign vertical_sync_output_oe = s_q.vs_oe;
  assign red_out                 = s_q.red;
  assign green_out               = s_q.green;
  assign blue_out                = s_q.blue;
  assign horizontal_sync_output  = s_q.hs_out;
  assign data_strobe_clock_out   = s_q.dclk;
  assign pixel_valid             = s_q.pix_v;
  assign address_strap_lsb       = s_q.strap;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_quiet_sample;
    (ev_s && !ph_wr) ##1 !ph_wr;
  endsequence

  sequence s_strap_agree;
    (s_q.st == POCS_ST_SAMPLE) && (s_q.syn[1][I_ST] == s_q.syn[2][I_ST]);
  endsequence

  a_strap_pin_released: assert property ((s_q.st != POCS_ST_RUN) |-> !vertical_sync_output_oe) // R1
    else $error("strap pin driven before sample");
  a_strap_value_taken: assert property (s_strap_agree |=> // R1
    (address_strap_lsb == $past(s_q.syn[2][I_ST]) && vertical_sync_output_oe))
    else $error("strap value not captured");
  a_vsync_follows_in: assert property ((s_q.st == POCS_ST_RUN) |=> // R2
    (vertical_sync_output_oe && vertical_sync_output_o ==
     ($past(s_q.filt[I_VS]) ^ $past(s_q.hsctl[`POCS_VS_POL_BIT]))))
    else $error("vertical sync not following input");
  a_fixed_latency: assert property (s_quiet_sample |=> ev_ro) // R4
    else $error("data clock edge not at fixed latency");
  a_phase_moves_all: assert property ((ph_wr && pstrb[0]) |=> // R5
    (ph == $past(pwdata[`POCS_PHASE_MSB:`POCS_PHASE_LSB])))
    else $error("phase write lost");
  a_pix_clock_edge: assert property ((sel == POCS_CK_PIX && ev_ro) |=> data_strobe_clock_out) // R6
    else $error("pixel clock not high after rise");
  a_half_toggles: assert property ((sel == POCS_CK_HALF && ev_ro) |=> // R8
    (data_strobe_clock_out != $past(data_strobe_clock_out)))
    else $error("half clock did not toggle");
  a_x2_quarter_low: assert property ((sel == POCS_CK_X2 && ev_q && !ev_ro && !ev_fo) |=> // R7
    !data_strobe_clock_out)
    else $error("double clock not low at quarter");
  sequence s_hs_into_empty;
    hs_start ##1 (bs.in_valid && bs.in_ready && !bs.out_valid) ##1 sink_ready;
  endsequence

  a_hsync_start: assert property (s_hs_into_empty |=> // R10
    (horizontal_sync_output == !$past(s_q.hsctl[`POCS_HS_POL_BIT], 3)))
    else $error("hsync start lost");
  a_apb_answer: assert property ((acc && !pready) |=> (pready ##1 !pready))
    else $error("apb answer timing wrong");
endmodule

// >>> dv/pocs_sink.sv
// Downstream sink model: captures each loaded word, can stall
// Assumes it shares pclk with the block
`timescale 1ns/10ps
module pocs_sink (
  input  wire logic        pclk,
  input  wire logic        pixel_valid,
  input  wire logic        dclk,
  input  wire logic [30:0] word,
  input  wire logic [1:0]  mode,
  output logic             sink_ready,
  output logic             cap_stb,
  output logic [31:0]      cap_word
);
  // ------------
  // Stall and capture
  // ------------
  logic [1:0] cnt = '0;
  // Mode 0 ready, 1 stalls one cycle in three, 2 holds off
  assign sink_ready = (mode == 2'h0) || (mode == 2'h1 && cnt != 2'h0);
  always @(posedge pclk)
  begin
    cnt <= (cnt == 2'h2) ? 2'h0 : cnt + 2'h1;
    cap_stb <= pixel_valid;
    cap_word <= {dclk, word};
  end
endmodule

// >>> dv/pixel_output_clock_select_test.sv
// Bench: APB registers, strap, video path against a queue model
// Assumes pocs_pkg, pocs_top and pocs_sink are compiled first
`timescale 1ns/10ps
`include "pocs_params.svh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin error_cnt++; \
  $display("FAIL %0t got %h exp %h", $time, (a), (b)); end end
module pixel_output_clock_select_test;
  import pocs_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, cap_word;
  logic        pready, pslverr, err, lclk = 0, lk_en = 0, hs_in = 0, vs_in = 0;
  logic        pull = 1, cmp_on = 0, cnt_on = 0, dclk_d = 0;
  logic [9:0]  r_in = '0, g_in = '0, b_in = '0, r_o, g_o, b_o;
  logic [1:0]  mode = '0, cksel = '0, lk_div = '0;
  logic        vs_o, vs_oe, vs_pin, strap, pv, sready, dclk, hs_o, cap_stb;
  logic [15:0] seed = 16'hDF59;
  int          error_cnt = 0, checks_done = 0, lat, lat_base = -1, ph = 0, edges, hs_cnt;
  longint      t_q[$];
  logic [29:0] w_q[$];

  // ------------
  // Clocks, pin, model
  // ------------
  always #10 pclk = ~pclk;
  assign vs_pin = vs_oe ? vs_o : pull;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Link clock from pclk steps, half period 4 cycles; data moves on its fall
  always @(posedge pclk)
  begin
    lk_div <= lk_en ? lk_div + 2'h1 : 2'h0;
    if (!lk_en)
      lclk <= 1'b0;
    else if (lk_div == 2'h3)
    begin
      lclk <= ~lclk;
      if (lclk)
      begin
        seed = lfsr(seed);
        r_in <= seed[9:0];
        g_in <= seed[15:6];
        b_in <= ~seed[9:0];
      end
      else if (cmp_on)
      begin
        w_q.push_back({r_in, g_in, b_in});
        t_q.push_back($time);
      end
    end
  end
  always @(posedge pclk)
  begin
    dclk_d <= dclk;
    if (cnt_on && dclk && !dclk_d)
      edges++;
    if (cap_stb === 1'b1 && cap_word[30] === 1'b0)
      hs_cnt++;
    // Sample instant ph+1 cycles after the rise: takes the word then on the pins
    if (cap_stb === 1'b1 && cmp_on && w_q.size() > (ph + 5) / 8)
    begin
      lat = int'(($time - t_q.pop_front()) / 20);
      if (lat_base < 0)
        lat_base = lat - ph;
      if (mode == 2'h0)
        `CHK(lat, lat_base + ph)
      `CHK(cap_word[29:0], w_q[(ph + 5) / 8])
      void'(w_q.pop_front());
      if (cksel < 2'h2)
        `CHK(cap_word[31], cksel == 2'h0)
    end
  end

  pocs_top dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hF),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_sample_clock_in(lclk), .hsync_in(hs_in), .vsync_in(vs_in),
    .adc_red(r_in), .adc_green(g_in), .adc_blue(b_in),
    .vertical_sync_output_i(vs_pin), .vertical_sync_output_o(vs_o),
    .vertical_sync_output_oe(vs_oe), .red_out(r_o), .green_out(g_o),
    .blue_out(b_o), .horizontal_sync_output(hs_o),
    .data_strobe_clock_out(dclk), .pixel_valid(pv), .sink_ready(sready),
    .address_strap_lsb(strap));
  pocs_sink sink (.pclk(pclk), .pixel_valid(pv), .dclk(dclk),
    .word({hs_o, r_o, g_o, b_o}), .mode(mode), .sink_ready(sready),
    .cap_stb(cap_stb), .cap_word(cap_word));

  // ------------
  // Tasks
  // ------------
  task test_done;
    $display("Comparisons %0d, mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
    begin
      error_cnt++;
      test_done();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rst(input logic p);
    int n;
    pull <= p;
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    n = 0;
    while (vs_oe !== 1'b1 && n < 200)
    begin
      @(posedge pclk);
      n++;
    end
    if (n == 200)
      error_cnt++;
    `CHK(strap, p)
    apb(12'h024, 1'b0, '0);
    `CHK(rd[1:0], {1'b1, p})
    vs_in <= 1'b1;
    repeat (12) @(posedge pclk);
    `CHK({vs_pin, vs_o}, 2'b11)
    vs_in <= 1'b0;
    repeat (12) @(posedge pclk);
    `CHK({vs_pin, strap}, {1'b0, p})
  endtask
  task automatic run(input int p, input logic [1:0] ck, input logic [1:0] m);
    int e;
    lk_en <= 1'b0;
    repeat (40) @(posedge pclk);
    w_q.delete();
    t_q.delete();
    ph = p;
    apb(12'h004, 1'b1, p << 3);
    apb(12'h004, 1'b0, '0);
    `CHK(rd[7:3], p[4:0])
    apb(12'h020, 1'b1, {24'h0, ck, 6'h00});
    apb(12'h020, 1'b0, '0);
    `CHK(rd[7:6], ck)
    cksel = ck;
    mode <= m;
    cmp_on <= 1'b1;
    lk_en <= 1'b1;
    repeat (40) @(posedge pclk);
    edges = 0;
    cnt_on <= 1'b1;
    repeat (160) @(posedge pclk);
    cnt_on <= 1'b0;
    cmp_on <= 1'b0;
    e = (ck == 2'h2) ? 40 : (ck == 2'h3) ? 10 : 20;
    `CHK(edges >= e - 1 && edges <= e + 1, 1'b1)
  endtask

  // ------------
  // Main sequence
  // ------------
  initial
  begin
    #1500000;
    error_cnt++;
    test_done();
  end
  initial
  begin
    rst(1'b1);
    apb(12'h004, 1'b0, '0);
    `CHK(rd[7:0], `POCS_RST_PHASE)
    apb(12'h020, 1'b0, '0);
    `CHK(rd[7:0], `POCS_RST_OCLK)
    apb(12'h028, 1'b0, '0);
    `CHK(rd[9:0], `POCS_RST_HSCTL)
    apb(12'h100, 1'b0, '0);
    `CHK({err, rd}, {1'b1, 32'h0})
    run(0, 2'h0, 2'h0);
    run(8, 2'h1, 2'h0);
    run(31, 2'h2, 2'h0);
    run(5, 2'h3, 2'h1);
    mode <= 2'h2;
    repeat (80) @(posedge pclk);
    apb(12'h024, 1'b0, '0);
    `CHK(rd[2], 1'b1)
    mode <= 2'h0;
    repeat (20) @(posedge pclk);
    apb(12'h024, 1'b1, 32'h4);
    apb(12'h024, 1'b0, '0);
    `CHK(rd[2], 1'b0)
    apb(12'h028, 1'b1, 32'h303);
    repeat (40) @(posedge pclk);
    `CHK(vs_pin, 1'b1)
    hs_cnt = 0;
    hs_in <= 1'b1;
    repeat (16) @(posedge pclk);
    hs_in <= 1'b0;
    repeat (120) @(posedge pclk);
    `CHK(hs_cnt, 3)
    rst(1'b0);
    apb(12'h020, 1'b0, '0);
    `CHK(rd[7:0], `POCS_RST_OCLK)
    test_done();
  end
endmodule
